// ===== hdl/gate_timer.sv
// Summary of operation
// - Polarity bit picks high or low active gate
// - Toggle mode off holds toggle flop clear
// - Toggle flop inverts on each gate rise
// - Single pulse mode controls gate when set
// - Go bit set arms, waits for edge
// - Go bit reads zero when done or idle
// - Read-only bit shows present gate level
// - Level bit ignores gate enable setting
// - Two-bit field selects among four gate sources
// - Sixteen-bit count via high and low bytes
// - Run clear stops count, clears toggle flop
// - Software arms go, falling level clears it
// - Falling level sets event flag, software clears
`timescale 1ns/100ps
`default_nettype none
module gate_timer
  import gate_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          full_reset_i,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [3:0]    adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Gate sources
  input  wire gate_pkg::gate_inputs_t gate_raw_i,
  // Interrupt
  output logic               irq_o
);
  import gate_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0]  ctl;
    logic        run;
    logic        toggle_ff;
    logic        sp_open;
    logic        level;
    logic        level_d1;
    logic        sel_d1;
    logic [15:0] count;
    logic        event_flag;
    logic        irq_en;
    logic        irq;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

  state_t q, d;
  logic   sel_gate;
  logic   polar;
  logic   rise;
  logic   wr;
  logic   rd;

  gate_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .src_i (gate_src_t'(q.ctl[BIT_SRC_HI:BIT_SRC_LO])),
    .raw_i (gate_raw_i),
    .sel_o (sel_gate)
  );

  function automatic logic byte_hit(input logic [3:0] a, input logic [3:0] want,
                                    input logic [3:0] s);
    byte_hit = (a == want) && s[0];
  endfunction : byte_hit

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    d       = q;
    wr      = cyc_i && stb_i && we_i && !q.ack;
    rd      = cyc_i && stb_i && !we_i && !q.ack;
    d.ack   = cyc_i && stb_i && !q.ack;
    d.sel_d1 = sel_gate;
    // Polarity folds into the source before toggling
    polar   = q.ctl[BIT_POLARITY] ? sel_gate : !sel_gate;
    // Active edge of the polarity-adjusted gate
    rise    = polar && !(q.ctl[BIT_POLARITY] ? q.sel_d1 : !q.sel_d1);
    if (!q.ctl[BIT_TOGGLE] || !q.run)
      d.toggle_ff = 1'b0;
    else if (rise)
      d.toggle_ff = !q.toggle_ff;
    // Armed acquisition opens only on a fresh edge
    // A gate already active when go is set must not start the pulse
    if (!q.ctl[BIT_SINGLE] || !q.ctl[BIT_GO])
      d.sp_open = 1'b0;
    else if (rise)
      d.sp_open = 1'b1;
    // Effective gate level, independent of gate enable
    d.level = q.ctl[BIT_TOGGLE] ? q.toggle_ff : polar;
    if (q.ctl[BIT_SINGLE])
      d.level = q.ctl[BIT_GO] && q.sp_open
                && (q.ctl[BIT_TOGGLE] ? q.toggle_ff : polar);
    d.level_d1 = q.level;
    // Counting
    if (q.run && (!q.ctl[BIT_GATE_ENABLE] || q.level))
      d.count = q.count + 16'h0001;
    // Falling edge of level
    if (q.level_d1 && !q.level)
    begin
      d.ctl[BIT_GO]  = 1'b0;
      d.event_flag   = 1'b1;
    end
    if (wr && sel_i[0])
    begin
      unique case (adr_i)
        ADDR_GATE_CONTROL:
        begin
          d.ctl[7:4] = dat_i[7:4];
          d.ctl[1:0] = dat_i[1:0];
          if (q.ctl[BIT_SINGLE] || dat_i[BIT_SINGLE])
            d.ctl[BIT_GO] = dat_i[BIT_GO] && !(q.level_d1 && !q.level);
        end
        ADDR_COUNT_LOW:  d.count[7:0]  = dat_i[7:0];
        ADDR_COUNT_HIGH: d.count[15:8] = dat_i[7:0];
        ADDR_RUN_CTL:
        begin
          d.run    = dat_i[BIT_RUN];
          d.irq_en = dat_i[8];
          // Write one clears the flag; a same-cycle edge still wins
          if (dat_i[16] && !(q.level_d1 && !q.level))
            d.event_flag = 1'b0;
        end
        default: ;
      endcase
    end
    d.rdata = '0;
    if (rd)
    begin
      unique case (adr_i)
        ADDR_GATE_CONTROL: d.rdata[7:0] = {q.ctl[7:3], q.level, q.ctl[1:0]};
        ADDR_COUNT_LOW:    d.rdata[7:0] = q.count[7:0];
        ADDR_COUNT_HIGH:   d.rdata[7:0] = q.count[15:8];
        ADDR_RUN_CTL:      d.rdata      = {15'h0000, q.event_flag, 7'h00, q.irq_en,
                                           7'h00, q.run};
        default:           d.rdata      = '0;
      endcase
    end
    d.irq = d.event_flag && d.irq_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.run        <= 1'b0;
      q.toggle_ff  <= 1'b0;
      q.sp_open    <= 1'b0;
      q.level      <= 1'b0;
      q.level_d1   <= 1'b0;
      q.sel_d1     <= 1'b0;
      q.count      <= COUNT_RESET;
      q.event_flag <= 1'b0;
      q.irq_en     <= 1'b0;
      q.irq        <= 1'b0;
      q.ack        <= 1'b0;
      q.rdata      <= '0;
      // Gate fields survive a warm reset
      q.ctl        <= full_reset_i ? GATE_CONTROL_RESET : q.ctl;
    end
    else
      q <= d;
  end

  assign dat_o = q.rdata;
  assign ack_o = q.ack;
  assign irq_o = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  sequence fall_s;
    q.level_d1 && !q.level;
  endsequence

  go_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_s |=> !q.ctl[BIT_GO]) else $error("go bit not cleared");
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fall_s |=> q.event_flag) else $error("event flag not set");
  toggle_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.ctl[BIT_TOGGLE] |=> !q.toggle_ff) else $error("toggle flop not held");
  run_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.run && !(wr && adr_i == ADDR_COUNT_LOW) && !(wr && adr_i == ADDR_COUNT_HIGH)
    |=> $stable(q.count)) else $error("count moved while stopped");
  gated_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.run && q.ctl[BIT_GATE_ENABLE] && !q.level && !wr |=> $stable(q.count))
    else $error("count moved with gate closed");
  free_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.run && !q.ctl[BIT_GATE_ENABLE] && !wr |=> q.count == $past(q.count) + 16'h0001)
    else $error("count did not advance");
  single_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ctl[BIT_SINGLE] && !q.ctl[BIT_GO] |=> !q.level) else $error("pulse without arm");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ack |=> !q.ack) else $error("ack held two cycles");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.irq |-> q.irq_en) else $error("interrupt not enabled");

  ////////////////////////////////////////////////////////////////////////////
  // Single pulse handshake steps
  sequence armed_s;
    q.ctl[BIT_SINGLE] && q.ctl[BIT_GO];
  endsequence

  sequence idle_arm_s;
    !q.ctl[BIT_SINGLE];
  endsequence

  sp_closed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    idle_arm_s |=> !q.sp_open)
    else $error("pulse window open outside single mode");

  go_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed_s ##0 !q.sp_open |=> !q.level)
    else $error("pulse started before gate edge");

  ////////////////////////////////////////////////////////////////////////////
  // Toggle flop and plain gate path
  toggle_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.run |=> !q.toggle_ff)
    else $error("toggle flop kept while stopped");

  plain_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.ctl[BIT_TOGGLE] && !q.ctl[BIT_SINGLE] |=> q.level == $past(polar))
    else $error("gate level not polarity adjusted");

  ////////////////////////////////////////////////////////////////////////////
  // Event flag is sticky until software clears it
  flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.event_flag && !(wr && adr_i == ADDR_RUN_CTL && dat_i[16]) |=> q.event_flag)
    else $error("event flag lost");

  go_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ctl[BIT_GO] && !(q.level_d1 && !q.level) && !wr |=> q.ctl[BIT_GO])
    else $error("go bit dropped without gate fall");

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer pairs with a taken request
  ack_taken_a: assert property (@(posedge clk_i) disable iff (rst_i)
    q.ack |-> $past(cyc_i && stb_i))
    else $error("ack without request");

endmodule : gate_timer
`default_nettype wire

// ===== common/gate_pkg.sv
`default_nettype none
package gate_pkg;

  // Register byte addresses (word aligned)
  localparam logic [3:0] ADDR_GATE_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNT_LOW    = 4'h4;
  localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h8;
  localparam logic [3:0] ADDR_RUN_CTL      = 4'hC;

  // Gate control field positions
  localparam int BIT_GATE_ENABLE = 7;
  localparam int BIT_POLARITY    = 6;
  localparam int BIT_TOGGLE      = 5;
  localparam int BIT_SINGLE      = 4;
  localparam int BIT_GO          = 3;
  localparam int BIT_LEVEL       = 2;
  localparam int BIT_SRC_HI      = 1;
  localparam int BIT_SRC_LO      = 0;

  // Run control register bits
  localparam int BIT_RUN         = 0;
  localparam int BIT_FULL_RESET  = 1;

  // Reset values
  localparam logic [7:0]  GATE_CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET        = 16'h0000;

  // Gate source codes
  typedef enum logic [1:0] {
    SRC_PIN   = 2'b00,
    SRC_OVF   = 2'b01,
    SRC_CMP_A = 2'b10,
    SRC_CMP_B = 2'b11
  } gate_src_t;

  // Raw gate inputs travelling together
  typedef struct packed {
    logic pin;
    logic ovf;
    logic cmp_a_sync_out;
    logic cmp_b_sync_out;
  } gate_inputs_t;

  // Classic Wishbone request
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage : gate_pkg
`default_nettype wire

// ===== hdl/gate_sync.sv
`timescale 1ns/100ps
`default_nettype none
module gate_sync
  import gate_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Raw and synchronised gate inputs
  input  wire gate_src_t    src_i,
  input  wire gate_inputs_t raw_i,
  output logic              sel_o
);

  typedef struct packed {
    gate_inputs_t s1;
    gate_inputs_t s2;
    logic         sel;
  } sync_state_t;

  sync_state_t q, d;

  always_comb
  begin
    d     = q;
    d.s1  = raw_i;
    d.s2  = q.s1;
    unique case (src_i)
      SRC_PIN:   d.sel = q.s2.pin;
      SRC_OVF:   d.sel = q.s2.ovf;
      SRC_CMP_A: d.sel = q.s2.cmp_a_sync_out;
      SRC_CMP_B: d.sel = q.s2.cmp_b_sync_out;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign sel_o = q.sel;

endmodule : gate_sync
`default_nettype wire

// ===== sim/gate_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module gate_src_model (
  // Clock
  input  wire logic                   clk_i,
  // Requested levels: pin, ovf, cmp a, cmp b
  input  wire logic [3:0]             lvl_i,
  // Raw gate sources
  output logic                        raw_o_pin,
  output gate_pkg::gate_inputs_t      raw_o
);
  import gate_pkg::*;
  // Sources move only after an edge, as launched logic would
  always_ff @(posedge clk_i)
  begin
    raw_o <= lvl_i;
  end
  assign raw_o_pin = raw_o.pin;
endmodule : gate_src_model
`default_nettype wire

// ===== sim/gate_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module gate_timer_tb;
  import gate_pkg::*;
  logic clk_i = 0, rst_i = 1, full_reset_i = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic [3:0] adr = 4'h0, lvl = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o, r;
  gate_inputs_t raw;
  int bad_count = 0, cmp_count = 0;
  typedef struct { logic [7:0] ctl; logic [3:0] lv; logic exp; } row_t;
  row_t rows [8] = '{'{8'h40, 4'h8, 1}, '{8'h41, 4'h4, 1}, '{8'h42, 4'h2, 1},
    '{8'h43, 4'h1, 1}, '{8'h41, 4'hB, 0}, '{8'h00, 4'h8, 0}, '{8'h00, 4'h0, 1},
    '{8'hC0, 4'h8, 1}};
  initial forever #2 clk_i = ~clk_i;
  gate_src_model src (.clk_i(clk_i), .lvl_i(lvl), .raw_o_pin(), .raw_o(raw));
  gate_timer uut (.clk_i(clk_i), .rst_i(rst_i), .full_reset_i(full_reset_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack), .gate_raw_i(raw), .irq_o(irq));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One classic cycle; request held until the edge that sees ack high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task automatic pin(input logic v);
    lvl <= {v, 3'b000};
    repeat (8) @(posedge clk_i);
  endtask : pin
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(4 * 5000);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0; full_reset_i <= 0;
    wb(0, ADDR_GATE_CONTROL, 0); chk("ctl_rst", r & 32'hFB, 0);
    foreach (rows[i])
    begin
      lvl <= rows[i].lv;
      wb(1, ADDR_GATE_CONTROL, rows[i].ctl);
      repeat (8) @(posedge clk_i);
      wb(0, ADDR_GATE_CONTROL, 0);
      chk("level", r[BIT_LEVEL], rows[i].exp);
    end
    pin(0);
    // Count holds while gate inactive, moves when active
    wb(1, ADDR_COUNT_LOW, 0); wb(1, ADDR_COUNT_HIGH, 32'h0000_0012);
    wb(1, ADDR_RUN_CTL, 32'h0001_0101);
    repeat (10) @(posedge clk_i);
    wb(0, ADDR_COUNT_HIGH, 0); chk("cnt_hi", r[7:0], 8'h12);
    wb(0, ADDR_COUNT_LOW, 0); chk("cnt_hold", r[7:0], 8'h00);
    chk("irq_idle", irq, 0);
    pin(1); pin(0);
    wb(0, ADDR_COUNT_LOW, 0); chk("cnt_move", r[7:0] != 0, 1);
    // Toggle: first rise opens the gate, second rise closes it
    wb(1, ADDR_GATE_CONTROL, 8'h60); wb(1, ADDR_RUN_CTL, 32'h0001_0101);
    pin(1); pin(0);
    wb(0, ADDR_GATE_CONTROL, 0); chk("tog_on", r[BIT_LEVEL], 1);
    chk("irq_quiet", irq, 0);
    pin(1); pin(0);
    wb(0, ADDR_GATE_CONTROL, 0); chk("tog_off", r[BIT_LEVEL], 0);
    chk("irq_set", irq, 1);
    wb(0, ADDR_RUN_CTL, 0); chk("flag", r[16], 1);
    wb(1, ADDR_RUN_CTL, 32'h0001_0101); chk("irq_clr", irq, 0);
    pin(1); pin(0); wb(1, ADDR_RUN_CTL, 32'h0000_0100);
    wb(0, ADDR_GATE_CONTROL, 0); chk("run_clr", r[BIT_LEVEL], 0);
    wb(1, ADDR_RUN_CTL, 32'h0000_0101); wb(1, ADDR_GATE_CONTROL, 8'h40);
    wb(0, ADDR_GATE_CONTROL, 0); chk("tm_off", r[BIT_LEVEL], 0);
    // Single pulse: go arms, gate fall ends acquisition
    wb(1, ADDR_GATE_CONTROL, 8'h50); wb(1, ADDR_GATE_CONTROL, 8'h58);
    wb(0, ADDR_GATE_CONTROL, 0); chk("go_arm", r[BIT_GO], 1);
    pin(1);
    wb(0, ADDR_GATE_CONTROL, 0); chk("sp_lvl", r[BIT_LEVEL], 1);
    pin(0);
    wb(0, ADDR_GATE_CONTROL, 0); chk("go_done", r[BIT_GO], 0);
    // Arming with the gate already active waits for a fresh edge
    pin(1);
    wb(1, ADDR_GATE_CONTROL, 8'h58);
    repeat (8) @(posedge clk_i);
    wb(0, ADDR_GATE_CONTROL, 0); chk("sp_wait", r[BIT_LEVEL], 0);
    pin(0); pin(1);
    wb(0, ADDR_GATE_CONTROL, 0); chk("sp_edge", r[BIT_LEVEL], 1);
    pin(0);
    wb(0, ADDR_GATE_CONTROL, 0); chk("go_done2", r[BIT_GO], 0);
    // Plain reset keeps fields, full reset clears them
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, ADDR_GATE_CONTROL, 0); chk("ctl_keep", r[7:4], 4'h5);
    @(posedge clk_i);
    rst_i        <= 1'b1;
    full_reset_i <= 1'b1;
    @(posedge clk_i);
    rst_i        <= 1'b0;
    full_reset_i <= 1'b0;
    wb(0, ADDR_GATE_CONTROL, 0); chk("ctl_clr", r & 32'hFB, 0);
    print_verdict();
  end
endmodule : gate_timer_tb
`default_nettype wire
